// [design/cct_pkg.sv]
// Constants shared by the capture/compare timer files.
// Assumes a 32-bit AHB-Lite register port with byte addresses.
package cct_pkg;
    localparam int unsigned CH_MAX = 4;
    localparam int unsigned CHM_W = 4;
    localparam int unsigned DT_W = 8;
    localparam int unsigned ST_W = 6;
    localparam int unsigned SLV_W = 3;
    localparam int unsigned PSC_W = 16;
    localparam int unsigned CTRL_W = 11;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PSC = 8'h04;
    localparam logic [7:0] OFS_ARR = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_DMAEN = 8'h18;
    localparam logic [7:0] OFS_DEAD = 8'h1C;
    localparam logic [7:0] OFS_CHMODE = 8'h20;
    localparam logic [7:0] OFS_CCR0 = 8'h30;
    localparam logic [7:0] CCR_STEP = 8'h04;
    // Control register fields
    localparam int unsigned C_EN = 0;
    localparam int unsigned C_DIR = 1;
    localparam int unsigned C_CTR = 2;
    localparam int unsigned C_OPM = 3;
    localparam int unsigned C_FRZ = 4;
    localparam int unsigned C_SLV = 8;
    // Status, mask and DMA enable fields
    localparam int unsigned ST_UPD = 0;
    localparam int unsigned ST_CC = 1;
    localparam int unsigned ST_TRG = 5;
    // Bus codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;
    typedef enum logic [SLV_W-1:0] {SLV_OFF, SLV_ENC, SLV_HALL, SLV_RESET, SLV_START} cct_slave_t;
    typedef enum logic [CHM_W-1:0] {CH_OFF, CH_TOGGLE, CH_PWM, CH_CAP_RISE, CH_CAP_FALL} cct_chmode_t;
endpackage : cct_pkg

// [design/cct_ch_if.sv]
// Link between the timer core and one capture/compare channel.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cct_ch_if
    import cct_pkg::*;
#(
    parameter int unsigned CNT_W = 16
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ccr;
    cct_chmode_t mode;
    logic step; // Counter took a new value this cycle
    logic ref_lvl;
    logic pin_lvl;
    logic cc_evt;
    logic [CNT_W-1:0] cap_val;
    modport core (output cnt, ccr, mode, step, input ref_lvl, pin_lvl, cc_evt, cap_val);
    modport chan (input cnt, ccr, mode, step, output ref_lvl, pin_lvl, cc_evt, cap_val);
endinterface : cct_ch_if

// [design/cct_channel.sv]
// One capture/compare channel: compare, PWM and input capture.
// Assumes pin_in is asynchronous; counter values come from the core.
`timescale 1ns/1ps
module cct_channel
    import cct_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin_in,
    cct_ch_if.chan chi
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic ref_lvl;
        logic cc_evt;
        logic [CNT_W-1:0] cap_val;
    } cct_chst_t;
    cct_chst_t q;
    cct_chst_t n;
    logic rise;
    logic fall;
    logic match;

    // Synchroniser, edge detect and channel function
    always_comb begin
        n = q;
        n.s1 = pin_in;
        n.s2 = q.s1;
        n.s3 = q.s2;
        rise = q.s2 & ~q.s3;
        fall = ~q.s2 & q.s3;
        match = chi.step && (chi.cnt == chi.ccr);
        n.cc_evt = 1'b0;
        case (chi.mode)
            CH_TOGGLE: begin
                n.ref_lvl = q.ref_lvl ^ match;
                n.cc_evt = match;
            end
            CH_PWM: begin
                // Compare of zero gives 0 %, above reload gives 100 %
                n.ref_lvl = chi.cnt < chi.ccr;
                n.cc_evt = match;
            end
            CH_CAP_RISE, CH_CAP_FALL: begin
                n.ref_lvl = 1'b0;
                n.cc_evt = (chi.mode == CH_CAP_RISE) ? rise : fall;
                n.cap_val = chi.cnt;
            end
            default: n.ref_lvl = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign chi.ref_lvl = q.ref_lvl;
    assign chi.pin_lvl = q.s2;
    assign chi.cc_evt = q.cc_evt;
    assign chi.cap_val = q.cap_val;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    pwm_zero_a: assert property (chi.mode == CH_PWM && chi.ccr == '0 |=> !q.ref_lvl)
        else $error("PWM with zero compare went high");
    pwm_full_a: assert property (chi.mode == CH_PWM && chi.ccr > chi.cnt |=> q.ref_lvl)
        else $error("PWM below compare stayed low");
    cap_take_a: assert property (chi.mode == CH_CAP_RISE && rise |=> q.cc_evt && q.cap_val == $past(chi.cnt))
        else $error("Rising edge not captured");
endmodule : cct_channel

// [design/cct_deadtime.sv]
// Complementary output pair with inserted dead time.
// Assumes ref_lvl comes from a flip-flop on the same clock.
`timescale 1ns/1ps
module cct_deadtime
    import cct_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ref_lvl,
    input wire logic en,
    input wire logic [DT_W-1:0] dead,
    output logic oc,
    output logic ocn
);
    typedef struct packed {
        logic prev;
        logic [DT_W-1:0] left;
        logic oc;
        logic ocn;
        logic [DT_W:0] idle;
    } cct_dtst_t;
    cct_dtst_t q;
    cct_dtst_t n;

    // Both low for dead+1 cycles after every change; also after enable
    always_comb begin
        n = q;
        n.prev = ref_lvl;
        n.idle = (q.oc || q.ocn) ? '0 : ((&q.idle) ? q.idle : q.idle + 1'b1);
        if (!en) begin
            n.oc = 1'b0;
            n.ocn = 1'b0;
            n.left = dead;
        end else if (ref_lvl != q.prev) begin
            n.oc = 1'b0;
            n.ocn = 1'b0;
            n.left = dead;
        end else if (q.left != '0) begin
            n.left = q.left - 1'b1;
        end else begin
            n.oc = ref_lvl;
            n.ocn = ~ref_lvl;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign oc = q.oc;
    assign ocn = q.ocn;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    pair_excl_a: assert property (!(q.oc && q.ocn))
        else $error("Both outputs of a pair active");
    dead_gap_a: assert property (($rose(q.oc) || $rose(q.ocn)) && $stable(dead) |-> q.idle > {1'b0, dead})
        else $error("Dead time shorter than programmed");
endmodule : cct_deadtime

// [design/cct_timer.sv]
// Prescaled auto-reload timer with capture/compare channels.
// Assumes one clock, AHB-Lite slave port, asynchronous channel pins.
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module cct_timer
    import cct_pkg::*;
#(
    parameter int unsigned CNT_W = 16,
    parameter int unsigned NUM_CH = 4,
    parameter int unsigned COMP_N = 3,
    parameter bit UPDOWN = 1'b1,
    parameter bit DMA_EN = 1'b1,
    parameter bit QUAD_EN = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NUM_CH-1:0] cc_in,
    output logic [NUM_CH-1:0] oc_out,
    output logic [NUM_CH-1:0] ocn_out,
    input wire logic dbg_halt,
    input wire logic trig_in,
    output logic trig_out,
    output logic dma_req,
    output logic irq
);
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [PSC_W-1:0] psc;
        logic [PSC_W-1:0] pcnt;
        logic [CNT_W-1:0] arr;
        logic [CNT_W-1:0] cnt;
        logic down;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        logic [ST_W-1:0] dmaen;
        logic [DT_W-1:0] dead;
        logic [NUM_CH*CHM_W-1:0] chmode;
        logic [NUM_CH-1:0][CNT_W-1:0] ccr;
        logic [7:0] a_adr;
        logic a_wr;
        logic [31:0] rdata;
        logic enc_a;
        logic enc_b;
        logic hall;
        logic step;
        logic upd;
        logic dma;
    } cct_state_t;
    cct_state_t q;
    cct_state_t n;

    cct_ch_if #(.CNT_W(CNT_W)) chi[NUM_CH] ();
    logic [CH_MAX-1:0] cc_evt;
    logic [CH_MAX-1:0] pin_v;
    logic [NUM_CH-1:0][CNT_W-1:0] cap_v;

    cct_slave_t slv;
    logic take;
    logic run;
    logic tick;
    logic ctr;
    logic dn;
    logic up;
    logic a_chg;
    logic b_chg;
    logic hall_x;
    logic enc_step;
    logic restart;
    logic adv;
    logic upd;
    logic trg;
    logic cnt_wr;
    logic ctrl_wr;
    logic [ST_W-1:0] clr;
    logic [ST_W-1:0] ev;

    function automatic logic [7:0] ccr_ofs(input int unsigned i);
        return 8'(OFS_CCR0 + CCR_STEP * i);
    endfunction : ccr_ofs

    function automatic cct_chmode_t chm(input logic [NUM_CH*CHM_W-1:0] v, input int unsigned i);
        return cct_chmode_t'(v[i*CHM_W +: CHM_W]);
    endfunction : chm

    // Read mux; unmapped offsets read as zero
    function automatic logic [31:0] rd_reg(input cct_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = '0;
        if (a == OFS_CTRL) begin
            r = 32'(s.ctrl);
        end else if (a == OFS_PSC) begin
            r = 32'(s.psc);
        end else if (a == OFS_ARR) begin
            r = 32'(s.arr);
        end else if (a == OFS_CNT) begin
            r = 32'(s.cnt);
        end else if (a == OFS_STAT) begin
            r = 32'(s.stat);
        end else if (a == OFS_MASK) begin
            r = 32'(s.mask);
        end else if (a == OFS_DMAEN) begin
            r = 32'(s.dmaen);
        end else if (a == OFS_DEAD) begin
            r = 32'(s.dead);
        end else if (a == OFS_CHMODE) begin
            r = 32'(s.chmode);
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (a == ccr_ofs(i)) begin
                r = 32'(s.ccr[i]);
            end
        end
        return r;
    endfunction : rd_reg

    // Counter, prescaler, slave modes, bus writes and flags
    always_comb begin
        n = q;
        slv = cct_slave_t'(q.ctrl[C_SLV +: SLV_W]);
        take = hsel && hready && htrans == HTRANS_NONSEQ;
        run = q.ctrl[C_EN] && !(q.ctrl[C_FRZ] && dbg_halt);
        tick = run && (q.pcnt >= q.psc);
        ctr = UPDOWN && q.ctrl[C_CTR] && slv != SLV_ENC;
        dn = UPDOWN && (ctr ? q.down : q.ctrl[C_DIR]);
        a_chg = pin_v[0] != q.enc_a;
        b_chg = pin_v[1] != q.enc_b;
        hall_x = ^pin_v[2:0];
        enc_step = QUAD_EN && slv == SLV_ENC && (a_chg != b_chg);
        restart = (QUAD_EN && slv == SLV_HALL && hall_x != q.hall) || (slv == SLV_RESET && trig_in);
        adv = run && (slv == SLV_ENC ? enc_step : tick);
        up = (slv == SLV_ENC) ? (a_chg ? (pin_v[0] != pin_v[1]) : (pin_v[0] == pin_v[1])) : !dn;
        cnt_wr = q.a_wr && q.a_adr == OFS_CNT;
        ctrl_wr = q.a_wr && q.a_adr == OFS_CTRL;
        upd = 1'b0;
        trg = (slv == SLV_START || slv == SLV_RESET) && trig_in;
        clr = '0;
        n.enc_a = pin_v[0];
        n.enc_b = pin_v[1];
        n.hall = hall_x;
        // Prescaler divides by psc + 1; a count left above a lowered psc ticks at once instead of wrapping
        if (run) begin
            n.pcnt = tick ? '0 : q.pcnt + 1'b1;
        end
        if (run && restart) begin
            if (slv == SLV_HALL) begin
                n.ccr[0] = q.cnt;
            end
            n.cnt = '0;
            n.pcnt = '0;
            upd = 1'b1;
            trg = 1'b1;
        end else if (adv) begin
            if (up) begin
                if (q.cnt >= q.arr) begin
                    if (ctr) begin
                        n.down = 1'b1;
                        n.cnt = q.cnt - 1'b1;
                    end else begin
                        n.cnt = '0;
                    end
                    upd = 1'b1;
                end else begin
                    n.cnt = q.cnt + 1'b1;
                end
            end else if (q.cnt == '0) begin
                if (ctr) begin
                    n.down = 1'b0;
                    n.cnt = q.cnt + 1'b1;
                end else begin
                    n.cnt = q.arr;
                end
                upd = 1'b1;
            end else begin
                n.cnt = q.cnt - 1'b1;
            end
        end
        n.step = adv || (run && restart);
        // One-pulse mode stops at the update; trigger may start the counter
        if (upd && q.ctrl[C_OPM]) begin
            n.ctrl[C_EN] = 1'b0;
        end
        if (slv == SLV_START && trig_in) begin
            n.ctrl[C_EN] = 1'b1;
        end
        // Captured values land in the compare registers
        for (int i = 0; i < NUM_CH; i++) begin
            if (cc_evt[i] && (chm(q.chmode, i) == CH_CAP_RISE || chm(q.chmode, i) == CH_CAP_FALL)) begin
                n.ccr[i] = cap_v[i];
            end
        end
        // Data phase of a write; software wins over the counter
        if (q.a_wr) begin
            if (q.a_adr == OFS_CTRL) begin
                n.ctrl = hwdata[CTRL_W-1:0];
            end else if (q.a_adr == OFS_PSC) begin
                n.psc = hwdata[PSC_W-1:0];
            end else if (q.a_adr == OFS_ARR) begin
                n.arr = hwdata[CNT_W-1:0];
            end else if (q.a_adr == OFS_CNT) begin
                n.cnt = hwdata[CNT_W-1:0];
            end else if (q.a_adr == OFS_STAT) begin
                clr = hwdata[ST_W-1:0];
            end else if (q.a_adr == OFS_MASK) begin
                n.mask = hwdata[ST_W-1:0];
            end else if (q.a_adr == OFS_DMAEN) begin
                n.dmaen = hwdata[ST_W-1:0];
            end else if (q.a_adr == OFS_DEAD) begin
                n.dead = hwdata[DT_W-1:0];
            end else if (q.a_adr == OFS_CHMODE) begin
                n.chmode = hwdata[NUM_CH*CHM_W-1:0];
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (q.a_adr == ccr_ofs(i)) begin
                    n.ccr[i] = hwdata[CNT_W-1:0];
                end
            end
        end
        // Sticky flags: a new event beats a same-cycle clear
        ev = '0;
        ev[ST_UPD] = upd;
        ev[ST_CC +: CH_MAX] = cc_evt;
        ev[ST_TRG] = trg;
        n.stat = (q.stat & ~clr) | ev;
        n.upd = upd;
        n.dma = DMA_EN && |(ev & q.dmaen);
        // Address phase; only whole-word writes are accepted
        n.a_wr = take && hwrite && hsize == HSIZE_WORD;
        n.a_adr = haddr[7:0];
        if (take && !hwrite) begin
            n.rdata = rd_reg(q, haddr[7:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
            q.arr <= '1;
        end else begin
            q <= n;
        end
    end

    // Channels, then output pairs where dead time is built in
    for (genvar g = 0; g < CH_MAX; g++) begin : gen_ch
        if (g < NUM_CH) begin : used
            assign chi[g].cnt = q.cnt;
            assign chi[g].ccr = q.ccr[g];
            assign chi[g].mode = chm(q.chmode, g);
            assign chi[g].step = q.step;
            assign cc_evt[g] = chi[g].cc_evt;
            assign pin_v[g] = chi[g].pin_lvl;
            assign cap_v[g] = chi[g].cap_val;
            cct_channel #(.CNT_W(CNT_W)) u_ch (
                .clk(clk),
                .rstn(rstn),
                .pin_in(cc_in[g]),
                .chi(chi[g])
            );
            if (g < COMP_N) begin : pair
                cct_deadtime u_dt (
                    .clk(clk),
                    .rstn(rstn),
                    .ref_lvl(chi[g].ref_lvl),
                    .en(chm(q.chmode, g) == CH_PWM || chm(q.chmode, g) == CH_TOGGLE),
                    .dead(q.dead),
                    .oc(oc_out[g]),
                    .ocn(ocn_out[g])
                );
            end else begin : single
                assign oc_out[g] = chi[g].ref_lvl;
                assign ocn_out[g] = 1'b0;
            end
        end else begin : pad
            assign cc_evt[g] = 1'b0;
            assign pin_v[g] = 1'b0;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = q.rdata;
    assign trig_out = q.upd;
    assign dma_req = q.dma;
    assign irq = |(q.stat & q.mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    psc_div_a: assert property (tick && $past(tick) && $past(run) && $stable(q.psc) |-> q.psc == '0)
        else $error("Prescaler ticked on adjacent cycles");
    up_wrap_a: assert property (adv && up && !ctr && q.cnt >= q.arr && !restart && !cnt_wr
        |=> q.cnt == '0 && q.upd && q.stat[ST_UPD])
        else $error("Upcount did not wrap with update");
    down_load_a: assert property (adv && !up && !ctr && q.cnt == '0 && !restart && !cnt_wr
        |=> q.cnt == $past(q.arr) && q.upd)
        else $error("Downcount did not reload");
    center_turn_a: assert property (adv && ctr && up && q.cnt >= q.arr && !restart && !ctrl_wr |=> q.down)
        else $error("Center mode did not turn down");
    freeze_hold_a: assert property (q.ctrl[C_FRZ] && dbg_halt && !cnt_wr |=> $stable(q.cnt))
        else $error("Counter moved while frozen");
    trig_start_a: assert property (slv == SLV_START && trig_in && !ctrl_wr |=> q.ctrl[C_EN])
        else $error("Trigger did not start counter");
    upd_irq_a: assert property (q.upd && q.mask[ST_UPD] |-> irq)
        else $error("Unmasked update gave no interrupt");
    arr_read_a: assert property (take && !hwrite && haddr[7:0] == OFS_ARR |=> hrdata == 32'($past(q.arr)))
        else $error("Reload register read back wrong");
    cv_wrap: cover property (q.upd);
    cv_center: cover property (adv && ctr && q.cnt >= q.arr);
    cv_enc: cover property (enc_step);
    cv_irq: cover property (irq);
endmodule : cct_timer

// [dv/cct_far_side.sv]
// Far-side model: sensor pins, linked timer trigger and power stage watch.
// Assumes the timer's clock; pin levels and trigger requests come from the bench.
`timescale 1ns/1ps
module cct_far_side #(
    parameter int unsigned N = 4
) (
    input wire logic clk,
    input wire logic [N-1:0] sense,
    input wire logic fire,
    input wire logic [N-1:0] oc,
    input wire logic [N-1:0] ocn,
    output logic [N-1:0] pins,
    output logic trig,
    output logic shoot
);
    // Sensors and the linked timer change just after the edge, like registered logic
    always @(posedge clk) begin
        pins <= sense;
        trig <= fire;
    end
    // Both switches of one leg on together would short the supply
    assign shoot = |(oc & ocn);
endmodule : cct_far_side

// [dv/configurable_capture_compare_timer_test.sv]
// Self-checking bench for the capture/compare timer, default four-channel build.
// Assumes zero-wait AHB-Lite slave; hready is fed back from hreadyout.
`timescale 1ns/1ps
module configurable_capture_compare_timer_test import cct_pkg::*;;
    logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, trig_in, trig_out, dma_req, irq, shoot, fire, dbg_halt;
    logic [31:0] haddr, hwdata, hrdata, rd, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] cc_in, oc_out, ocn_out, sense;
    int num_errors = 0, checks = 0, n, lo, hi_n, dma_n, sh;
    bit first;
    // Quadrature steps from A=B=1, each one count up
    logic [3:0] enc_seq[4] = '{4'h2, 4'h0, 4'h1, 4'h3};
    typedef struct {logic [31:0] ctrl, psc, arr; int per;} cct_row_t;
    // Enable, down, center: update spacing in clocks
    cct_row_t rows[4] = '{'{32'h1, 32'h0, 32'h2, 3}, '{32'h1, 32'h2, 32'h4, 15}, '{32'h3, 32'h1, 32'h3, 8},
        '{32'h5, 32'h0, 32'h5, 5}};
    assign hready = hreadyout;
    cct_timer dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cc_in(cc_in), .oc_out(oc_out), .ocn_out(ocn_out), .dbg_halt(dbg_halt), .trig_in(trig_in),
        .trig_out(trig_out), .dma_req(dma_req), .irq(irq));
    cct_far_side far_u (.clk(clk), .sense(sense), .fire(fire), .oc(oc_out), .ocn(ocn_out), .pins(cc_in),
        .trig(trig_in), .shoot(shoot));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // DMA pulses are one cycle wide, so count them as they pass
    always @(posedge clk) begin
        if (dma_req === 1'b1) dma_n++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One single transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic period(output int p);
        p = 0;
        do @(posedge clk); while (trig_out !== 1'b1);
        do begin
            @(posedge clk);
            p++;
        end while (trig_out !== 1'b1);
    endtask : period
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask : do_reset
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end
    initial begin
        {rstn, hsel, hwrite, fire, dbg_halt, htrans, hsize, haddr, hwdata, sense} = '0;
        do_reset();
        // Time base in each counting mode, prescaler in front
        foreach (rows[i]) begin
            bus(1'b1, OFS_CTRL, 32'h0);
            bus(1'b1, OFS_CNT, 32'h0);
            bus(1'b1, OFS_PSC, rows[i].psc);
            bus(1'b1, OFS_ARR, rows[i].arr);
            bus(1'b1, OFS_CTRL, rows[i].ctrl);
            period(n);
            period(n);
            check(n, rows[i].per);
        end
        $display("test period done");
        // Freeze while halted, run again when released
        bus(1'b1, OFS_ARR, 32'hFF);
        dbg_halt <= 1'b1;
        bus(1'b1, OFS_CTRL, 32'h11);
        bus(1'b0, OFS_CNT, 32'h0);
        v = rd;
        repeat (5) @(posedge clk);
        bus(1'b0, OFS_CNT, 32'h0);
        check(rd, v);
        dbg_halt <= 1'b0;
        bus(1'b0, OFS_CNT, 32'h0);
        bus(1'b0, OFS_CNT, 32'h0);
        check(rd - v > 0, 1);
        $display("test freeze done");
        // Update flag, mask, write-one clear, DMA request
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_STAT, 32'h3F);
        bus(1'b1, OFS_DMAEN, 32'h1);
        bus(1'b1, OFS_CNT, 32'hFE);
        dma_n = 0;
        bus(1'b1, OFS_CTRL, 32'h1);
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b0, OFS_STAT, 32'h0);
        check(rd & 32'h1, 32'h1);
        check(dma_n > 0, 1);
        @(posedge clk) check(irq, 1'b0);
        bus(1'b1, OFS_MASK, 32'h1);
        @(posedge clk) check(irq, 1'b1);
        bus(1'b1, OFS_STAT, 32'h1);
        @(posedge clk) check(irq, 1'b0);
        $display("test irq done");
        // One-pulse: enable drops at the first update
        bus(1'b1, OFS_ARR, 32'h3);
        bus(1'b1, OFS_CNT, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h9);
        repeat (12) @(posedge clk);
        bus(1'b0, OFS_CTRL, 32'h0);
        check(rd & 32'h1, 32'h0);
        // Start on a trigger from the linked timer
        bus(1'b1, OFS_CTRL, 32'h400);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (3) @(posedge clk);
        bus(1'b0, OFS_CTRL, 32'h0);
        check(rd & 32'h1, 32'h1);
        $display("test pulse and trigger done");
        // PWM on a complementary pair: no overlap, low gap of dead plus one
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_CNT, 32'h0);
        bus(1'b1, OFS_ARR, 32'h13);
        bus(1'b1, OFS_DEAD, 32'h3);
        bus(1'b1, OFS_CHMODE, 32'h2);
        bus(1'b1, OFS_CCR0, 32'h0A);
        bus(1'b1, OFS_CTRL, 32'h1);
        {lo, hi_n, sh, first} = '0;
        first = 1'b1;
        repeat (200) begin
            @(posedge clk);
            sh += (shoot !== 1'b0);
            if (oc_out[0] | ocn_out[0]) begin
                if (lo != 0 && !first) check(lo, 4);
                if (lo != 0) first = 1'b0;
                lo = 0;
                hi_n += oc_out[0];
            end else lo++;
        end
        check(sh, 0);
        check(hi_n > 0, 1);
        // Zero duty keeps the main output low
        bus(1'b1, OFS_CCR0, 32'h0);
        repeat (40) @(posedge clk);
        hi_n = 0;
        repeat (40) @(posedge clk) hi_n += (oc_out[0] !== 1'b0);
        check(hi_n, 0);
        $display("test pwm done");
        // Rising edge from the sensor captures into channel 1
        bus(1'b1, OFS_CHMODE, 32'h30);
        bus(1'b1, OFS_STAT, 32'h3F);
        sense <= 4'h2;
        repeat (8) @(posedge clk);
        bus(1'b0, OFS_STAT, 32'h0);
        check(rd & 32'h4, 32'h4);
        $display("test capture done");
        // Hall change restarts the counter and captures it; encoder counts every pin edge
        bus(1'b1, OFS_CNT, 32'h0);
        bus(1'b1, OFS_STAT, 32'h3F);
        bus(1'b1, OFS_CTRL, 32'h201);
        repeat (10) @(posedge clk);
        sense <= 4'h3;
        repeat (8) @(posedge clk);
        bus(1'b0, OFS_STAT, 32'h0);
        check(rd & 32'h21, 32'h21);
        bus(1'b0, OFS_CCR0, 32'h0);
        check(rd != 0, 1);
        bus(1'b1, OFS_CTRL, 32'h101);
        bus(1'b1, OFS_CNT, 32'h0);
        foreach (enc_seq[i]) begin
            sense <= enc_seq[i];
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        bus(1'b0, OFS_CNT, 32'h0);
        check(rd, 32'h4);
        $display("test hall and encoder done");
        // Reset in mid-run restores register values; unmapped reads give zero
        do_reset();
        bus(1'b0, OFS_ARR, 32'h0);
        check(rd, 32'h0000FFFF);
        bus(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        check(oc_out, 4'h0);
        $display("test reset done");
        results();
    end
endmodule : configurable_capture_compare_timer_test
